// ---- core/ufn_cfg.svh ----
`ifndef UFN_CFG_SVH
`define UFN_CFG_SVH
// sfr addresses
`define UFN_ADDR_FRAME_LOW 8'hba
`define UFN_ADDR_FRAME_HIGH 8'hbb
`define UFN_ADDR_EP_IRQ_EN 8'hc2
// field positions in the high frame register
`define UFN_BIT_CRC_GOOD 5
`define UFN_BIT_CRC_BAD 4
// reset values
`define UFN_RST_FRAME_HIGH 8'h00
`define UFN_RST_FRAME_LOW 8'h00
`define UFN_RST_EP_IRQ_EN 8'h00
// implemented bits of the enable register
`define UFN_EP_EN_MASK 8'h7f
`define UFN_EP_COUNT 7
`endif

// ---- core/ufn_pkg.sv ----
package ufn_pkg;
    typedef logic [10:0] ufn_frame_t;
    // one received start-of-frame report from the serial engine
    typedef struct packed {
        logic pid_seen;
        logic done;
        logic crc_ok;
        ufn_frame_t frame_index;
    } ufn_sof_s;
    // cpu special function register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ufn_sfr_s;
endpackage

// ---- core/ufn_ep_irq.sv ----
`timescale 1ns/10ps
`include "ufn_cfg.svh"
// per endpoint flag and gated request
module ufn_ep_irq
(
    input wire logic ref_clk_in, // core clock
    input wire logic rst_in, // async reset
    input wire logic [4:0] src_in, // endpoint status sources
    input wire logic en_in, // endpoint enable bit
    output logic flag_out, // endpoint irq flag
    output logic req_out // gated request
);
    logic flag_reg; // registered flag
    logic flag_next; // next flag
    // flag follows its sources: set while any is set, cleared when all are clear
    always_comb
    begin
        flag_next = |src_in;
    end
    // register the flag
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            flag_reg <= 1'b0;
        end
        else
        begin
            flag_reg <= flag_next;
        end
    end
    assign flag_out = flag_reg;
    assign req_out = flag_reg & en_in;
    // flag is the or of the sources one edge earlier, and clear on the first edge after reset
    AST_FLAG_TRACK: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        flag_reg == ($past(|src_in) && !$past(rst_in)))
        else $error("flag does not follow sources");
    // a disabled endpoint never raises its request
    AST_REQ_GATE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !en_in |-> !req_out)
        else $error("request while disabled");
endmodule

// ---- core/ufn_regs.sv ----
`timescale 1ns/10ps
`include "ufn_cfg.svh"

// Summary of operation
// - reserved bits read zero, writes ignored
// - enable bits 0..6 map to endpoints
// - enabled set flag raises usb request
// - flag set by sources, cleared when none
// - high bit 5 shows good sof crc
// - high bit 4 shows bad sof crc
// - sof interrupt right after pid receipt
// - high bits 2..0 hold frame bits 10..8
// - low register holds frame bits 7..0
// - frame number from latest sof packet
// - frame loaded even on bad crc
// - frame registers read-only, high resets zero

module ufn_regs
(
    input wire logic ref_clk_in, // core clock
    input wire logic rst_in, // async reset, active high
    input wire ufn_pkg::ufn_sfr_s sfr_in, // cpu register access
    output logic [7:0] sfr_rdata_out, // read data
    input wire ufn_pkg::ufn_sof_s sof_in, // sof report from serial engine
    input wire logic [34:0] ep_src_in, // five sources per endpoint
    output logic [6:0] ep_flag_out, // endpoint irq flags
    output logic usb_irq_out, // usb interrupt request
    output logic sof_irq_out // sof interrupt pulse
);
    logic [7:0] ep_en_reg; // endpoint enable register
    logic [7:0] ep_en_next; // next enable value
    logic [7:0] fr_low_reg; // frame low register
    logic [7:0] fr_low_next; // next frame low
    logic [7:0] fr_high_reg; // frame high register
    logic [7:0] fr_high_next; // next frame high
    logic sof_irq_reg; // sof pulse
    logic sof_irq_next; // next sof pulse
    logic [7:0] rdata_reg; // read data register
    logic [7:0] rdata_next; // next read data
    logic [6:0] ep_req; // per endpoint gated requests

    // per endpoint flag logic
    genvar gi;
    generate
        for (gi = 0; gi < `UFN_EP_COUNT; gi = gi + 1)
        begin : g_ep
            ufn_ep_irq u_ep
            (
                .ref_clk_in(ref_clk_in),
                .rst_in(rst_in),
                .src_in(ep_src_in[gi*5 +: 5]),
                .en_in(ep_en_reg[gi]),
                .flag_out(ep_flag_out[gi]),
                .req_out(ep_req[gi])
            );
            // an enabled endpoint flag must reach the shared request line
            AST_EP_REQ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
                ep_flag_out[gi] && ep_en_reg[gi] |-> usb_irq_out)
                else $error("enabled endpoint flag lost");
            // each enable bit gates only the endpoint of the same number
            AST_EP_GATE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
                !ep_en_reg[gi] |-> !ep_req[gi])
                else $error("enable bit gates wrong endpoint");
        end
    endgenerate

    // enable register write; reserved bit forced low
    always_comb
    begin
        ep_en_next = ep_en_reg;
        if (sfr_in.wr && sfr_in.addr == `UFN_ADDR_EP_IRQ_EN)
        begin
            ep_en_next = sfr_in.wdata & `UFN_EP_EN_MASK;
        end
    end

    // frame registers: loaded by hardware only, cpu writes ignored
    always_comb
    begin
        fr_low_next = fr_low_reg;
        fr_high_next = fr_high_reg;
        sof_irq_next = sof_in.pid_seen;
        if (sof_in.done)
        begin
            // loaded whatever the crc outcome
            fr_low_next = sof_in.frame_index[7:0];
            fr_high_next = 8'h00;
            fr_high_next[2:0] = sof_in.frame_index[10:8];
            fr_high_next[`UFN_BIT_CRC_GOOD] = sof_in.crc_ok;
            fr_high_next[`UFN_BIT_CRC_BAD] = ~sof_in.crc_ok;
        end
    end

    // read mux; unmapped addresses read zero
    always_comb
    begin
        rdata_next = 8'h00;
        if (sfr_in.rd)
        begin
            case (sfr_in.addr)
                `UFN_ADDR_FRAME_LOW: rdata_next = fr_low_reg;
                `UFN_ADDR_FRAME_HIGH: rdata_next = fr_high_reg;
                `UFN_ADDR_EP_IRQ_EN: rdata_next = ep_en_reg;
                default: rdata_next = 8'h00;
            endcase
        end
    end

    // enable group: cleared by reset, loaded by cpu writes
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            ep_en_reg <= `UFN_RST_EP_IRQ_EN;
        end
        else
        begin
            ep_en_reg <= ep_en_next;
        end
    end

    // frame group: frame fields, crc flags and the sof pulse
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            fr_low_reg <= `UFN_RST_FRAME_LOW;
            fr_high_reg <= `UFN_RST_FRAME_HIGH;
            sof_irq_reg <= 1'b0;
        end
        else
        begin
            fr_low_reg <= fr_low_next;
            fr_high_reg <= fr_high_next;
            sof_irq_reg <= sof_irq_next;
        end
    end

    // read data group: the answer stands for one cycle after the strobe
    always_ff @(posedge ref_clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rdata_reg <= 8'h00;
        end
        else
        begin
            rdata_reg <= rdata_next;
        end
    end

    // outputs straight from the registers and the gated requests
    assign sfr_rdata_out = rdata_reg;
    assign usb_irq_out = |ep_req;
    assign sof_irq_out = sof_irq_reg;

    // reserved enable bit never holds a one
    AST_RSVD_EN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        ep_en_reg[7] == 1'b0)
        else $error("reserved enable bit set");
    // reserved frame bits never hold a one
    AST_RSVD_HIGH: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        fr_high_reg[7:6] == 2'b00 && fr_high_reg[3] == 1'b0)
        else $error("reserved frame bit set");
    // a cpu write to the enable register lands on the next edge
    AST_EN_WRITE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sfr_in.wr && sfr_in.addr == `UFN_ADDR_EP_IRQ_EN |=> ep_en_reg[6:0] == $past(sfr_in.wdata[6:0]))
        else $error("enable write lost");
    // the shared request is the or of the enabled flags
    AST_IRQ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        usb_irq_out == |(ep_flag_out & ep_en_reg[6:0]))
        else $error("usb request mismatch");

    // crc good flag follows the packet just checked
    AST_CRC_GOOD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sof_in.done |=> fr_high_reg[5] == $past(sof_in.crc_ok))
        else $error("crc good flag wrong");
    // crc bad flag shows the opposite outcome
    AST_CRC_BAD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sof_in.done |=> fr_high_reg[4] == !$past(sof_in.crc_ok))
        else $error("crc bad flag wrong");
    // sof interrupt one edge after the pid
    AST_SOF_IRQ: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sof_in.pid_seen |=> sof_irq_out)
        else $error("sof irq late");
    // the frame index lands whole, whatever the crc outcome
    AST_FRAME: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sof_in.done |=> {fr_high_reg[2:0], fr_low_reg} == $past(sof_in.frame_index))
        else $error("frame not loaded");
    // nothing but a finished sof changes the frame registers
    AST_RO: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !sof_in.done |=> $stable(fr_low_reg) && $stable(fr_high_reg))
        else $error("frame changed without sof");
    // never both crc flags at once
    AST_ONEHOT: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        (fr_high_reg[5:4] != 2'b00) |-> (fr_high_reg[5] ^ fr_high_reg[4]))
        else $error("crc flags both set");

    // enable register checks
    // enable register keeps its value without a write to it
    AST_EN_HOLD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !(sfr_in.wr && sfr_in.addr == `UFN_ADDR_EP_IRQ_EN) |=> $stable(ep_en_reg))
        else $error("enable changed without write");
    // a one written to the reserved enable bit is dropped
    AST_EN_RSVD_WR: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sfr_in.wr && sfr_in.addr == `UFN_ADDR_EP_IRQ_EN && sfr_in.wdata[7] |=> ep_en_reg[7] == 1'b0)
        else $error("reserved enable bit kept");

    // read path checks: the answer comes one edge after the strobe
    // enable register reads back with its reserved bit low
    AST_RD_EN: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sfr_in.rd && sfr_in.addr == `UFN_ADDR_EP_IRQ_EN |=> sfr_rdata_out == $past(ep_en_reg))
        else $error("enable read wrong");
    // low frame register reads back its eight bits
    AST_RD_LOW: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sfr_in.rd && sfr_in.addr == `UFN_ADDR_FRAME_LOW |=> sfr_rdata_out == $past(fr_low_reg))
        else $error("frame low read wrong");
    // high frame register reads back its fields
    AST_RD_HIGH: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sfr_in.rd && sfr_in.addr == `UFN_ADDR_FRAME_HIGH |=> sfr_rdata_out == $past(fr_high_reg))
        else $error("frame high read wrong");
    // reserved places of the high frame register read zero
    AST_RD_RSVD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sfr_in.rd && sfr_in.addr == `UFN_ADDR_FRAME_HIGH |=> sfr_rdata_out[7:6] == 2'b00 && sfr_rdata_out[3] == 1'b0)
        else $error("reserved frame bit read");
    // no strobe, no data
    AST_RD_IDLE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !sfr_in.rd |=> sfr_rdata_out == 8'h00)
        else $error("read data without strobe");

    // sof pulse only follows a pid, and the crc flags wait for the check
    AST_SOF_PULSE: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        !sof_in.pid_seen |=> !sof_irq_out)
        else $error("sof irq without pid");
    // the pid alone leaves the crc flags as they were
    AST_SOF_NO_LOAD: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sof_in.pid_seen && !sof_in.done |=> $stable(fr_high_reg[5:4]))
        else $error("crc flags moved at pid");
    // once the check is done exactly one crc flag is set
    AST_CRC_EXCL: assert property (@(posedge ref_clk_in) disable iff (rst_in)
        sof_in.done |=> fr_high_reg[5] != fr_high_reg[4])
        else $error("crc flags not exclusive");
endmodule

// ---- tb/ufn_sof_host.sv ----
`timescale 1ns/10ps
// host side model: one sof report per request from the bench
module ufn_sof_host
(
    input wire logic ref_clk_in, // core clock
    input wire logic go_in, // start one sof packet
    input wire logic good_in, // crc of this packet is good
    input wire logic [10:0] idx_in, // frame index to carry
    output ufn_pkg::ufn_sof_s sof_out // report to the device
);
    // pid pulse first, result two cycles later; idle fields toggle
    initial
    begin
        sof_out = '0;
        forever
        begin
            @(posedge ref_clk_in iff go_in);
            #1 sof_out = {1'b1, 1'b0, ~good_in, ~idx_in};
            @(posedge ref_clk_in);
            #1 sof_out.pid_seen = 1'b0;
            @(posedge ref_clk_in);
            #1 sof_out = {1'b0, 1'b1, good_in, idx_in};
            @(posedge ref_clk_in);
            #1 sof_out = {1'b0, 1'b0, ~good_in, ~idx_in};
        end
    end
endmodule

// ---- tb/ufn_test.sv ----
`timescale 1ns/10ps
// bench for the frame number and endpoint enable registers
module usb_frame_number_ep_irq_enable_test;
    logic ref_clk_in = 1'b0; // core clock
    logic rst_in = 1'b1; // async reset
    ufn_pkg::ufn_sfr_s sfr = '0; // cpu access
    logic [7:0] rdata; // read data
    ufn_pkg::ufn_sof_s sof; // host report
    logic [34:0] src = '0; // endpoint sources
    logic [6:0] flag; // endpoint flags
    logic usb_irq, sof_irq, go = 1'b0, good = 1'b0; // irqs and host control
    logic [10:0] idx = '0; // frame to send
    int errors = 0, checks_done = 0; // tallies
    always #2 ref_clk_in = ~ref_clk_in;
    ufn_regs dut (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .sfr_in(sfr), .sfr_rdata_out(rdata), .sof_in(sof),
        .ep_src_in(src), .ep_flag_out(flag), .usb_irq_out(usb_irq), .sof_irq_out(sof_irq));
    ufn_sof_host host (.ref_clk_in(ref_clk_in), .go_in(go), .good_in(good), .idx_in(idx), .sof_out(sof));
    // compare and count
    task automatic check(input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        #1 sfr = {1'b1, 1'b0, a, d};
        @(posedge ref_clk_in);
        #1 sfr = '0;
    endtask
    // one register read, data shows the cycle after
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        #1 sfr = {1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk_in);
        #1 sfr = '0;
        d = rdata;
    endtask
    // reset values, reserved bit, read-only and unmapped places
    task automatic regs_scenario();
        logic [7:0] d;
        rd(8'hbb, d); check(d, 8'h00);
        rd(8'hc2, d);
        check(d, 8'h00);
        wr(8'hba, 8'hff);
        rd(8'hba, d);
        check(d, 8'h00);
        wr(8'hc2, 8'hff);
        rd(8'hc2, d); check(d, 8'h7f);
        wr(8'hbb, 8'hff);
        rd(8'hbb, d); check(d, 8'h00);
        rd(8'hc5, d); check(d, 8'h00);
    endtask
    // each endpoint alone, enabled then masked
    task automatic irq_scenario();
        for (int n = 0; n < 7; n++)
        begin
            wr(8'hc2, 8'h01 << n);
            src = '0;
            src[5 * n + 2] = 1'b1;
            repeat (2) @(posedge ref_clk_in);
            #1 check(flag, 7'h01 << n);
            check(usb_irq, 1'b1);
            wr(8'hc2, ~(8'h01 << n) & 8'h7f);
            check(usb_irq, 1'b0);
        end
        src = '0;
        repeat (2) @(posedge ref_clk_in);
        #1 check(flag, 7'h00);
    endtask
    // one sof packet, then the stored number and crc flags
    task automatic sof_scenario(input logic g, input logic [10:0] f, input logic [7:0] hi);
        logic [7:0] d;
        @(posedge ref_clk_in);
        #1 good = g;
        idx = f;
        go = 1'b1;
        @(posedge ref_clk_in);
        #1 go = 1'b0;
        @(posedge ref_clk_in);
        #1 check(sof_irq, 1'b1);
        @(posedge ref_clk_in);
        #1 check(sof_irq, 1'b0);
        repeat (2) @(posedge ref_clk_in);
        rd(8'hbb, d); check(d, hi);
        rd(8'hba, d); check(d, f[7:0]);
    endtask
    // reset in mid-run clears the enable and frame registers
    task automatic reset_scenario();
        logic [7:0] d;
        @(posedge ref_clk_in);
        #1 rst_in = 1'b1;
        @(posedge ref_clk_in);
        #1 rst_in = 1'b0;
        check(sof_irq, 1'b0);
        rd(8'hbb, d);
        check(d, 8'h00);
        rd(8'hc2, d);
        check(d, 8'h00);
        rd(8'hba, d);
        check(d, 8'h00);
    endtask
    // verdict and end of run
    task automatic wrap_up();
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (2) @(posedge ref_clk_in);
        #1 rst_in = 1'b0;
        regs_scenario();
        irq_scenario();
        sof_scenario(1'b1, 11'h7ff, 8'h27);
        sof_scenario(1'b0, 11'h123, 8'h11);
        reset_scenario();
        wrap_up();
    end
    // hang guard
    initial
    begin
        #20000 errors++;
        wrap_up();
    end
endmodule
